// ===== spm_bitrate.sv
`default_nettype none

module spm_bitrate (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic                       run,
  input  wire logic [spm_pkg::DIV_W-1:0]  divisor,
  output var  logic                       tick
);

  // ==========================================================
  // Phase lengths
  logic [spm_pkg::LEN_W-1:0] ratio;
  logic [spm_pkg::LEN_W-1:0] short_len;
  logic [spm_pkg::LEN_W-1:0] long_len;
  logic [spm_pkg::LEN_W-1:0] len;
  logic [spm_pkg::LEN_W-1:0] cnt_q;
  logic                      long_q;

  always_comb begin
    ratio = (divisor < spm_pkg::DIV_MIN_RAW) ? spm_pkg::RATIO_MIN
          : ({1'b0, divisor} + spm_pkg::LEN_ONE);
    // Odd ratio: long half first, short half second
    short_len = ratio >> 1;
    long_len  = ratio - short_len;
    len       = long_q ? long_len : short_len;
  end

  // ==========================================================
  // Counter; tick registered one cycle early so the user acts on the wrap
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      cnt_q  <= '0;
      long_q <= 1'b1;
      tick   <= 1'b0;
    end else begin
      tick <= (cnt_q == len - spm_pkg::LEN_TWO);
      if (cnt_q == len - spm_pkg::LEN_ONE) begin
        cnt_q  <= '0;
        long_q <= ~long_q;
      end else begin
        cnt_q <= cnt_q + spm_pkg::LEN_ONE;
      end
    end
  end

endmodule : spm_bitrate

`default_nettype wire

// ===== spm_pkg.sv
`default_nettype none

package spm_pkg;

  // ==========================================================
  // Bus geometry and counter widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned WORD_W = 8;
  localparam int unsigned DIV_W  = 7;
  localparam int unsigned LEN_W  = 8;
  localparam int unsigned EDGE_W = 5;

  // ==========================================================
  // Register byte addresses
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CONFIG  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DIVISOR = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_TXDATA  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_RXDATA  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h14;

  // ==========================================================
  // Field positions
  localparam int unsigned CTL_MASTER_BIT = 2;
  localparam int unsigned CTL_PHASE_BIT  = 3;
  localparam int unsigned CFG_POL_BIT    = 6;
  localparam int unsigned STS_BUSY_BIT   = 0;
  localparam int unsigned STS_DONE_BIT   = 1;

  // ==========================================================
  // Reset values and codes
  localparam logic [DATA_W-1:0] CONTROL_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] CONFIG_RST  = 32'h0000_0000;
  localparam logic [DIV_W-1:0]  DIVISOR_RST = 7'h00;
  localparam logic [WORD_W-1:0] WORD_RST    = 8'h00;
  localparam logic [1:0]        RESP_OKAY   = 2'h0;
  localparam logic [1:0]        RESP_SLVERR = 2'h2;

  // ==========================================================
  // Divider limits
  localparam logic [DIV_W-1:0]  DIV_MIN_RAW = 7'h03;
  localparam logic [LEN_W-1:0]  RATIO_MIN   = 8'h04;
  localparam logic [LEN_W-1:0]  LEN_ONE     = 8'h01;
  localparam logic [LEN_W-1:0]  LEN_TWO     = 8'h02;
  localparam logic [EDGE_W-1:0] EDGE_ONE    = 5'h01;
  localparam logic [EDGE_W-1:0] EDGE_LAST   = 5'h10;

  typedef enum logic [1:0] {
    SPM_IDLE = 2'b01,
    SPM_XFER = 2'b10
  } spm_state_t;

endpackage : spm_pkg

`default_nettype wire

// ===== spm_properties.sv
`default_nettype none

module spm_properties (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        serial_bit_clock,
  input wire logic        master_out_line,
  input wire logic        slave_select_strobe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  wa_q, ctl_q, hold_q, n_w, s_w, l_w;
  logic [31:0] wd_q;
  logic [6:0]  div_q;
  logic [3:0]  nb_q;
  logic        pol_q, sclk_q, ssn_q, ev_w, act_w;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================================
  // Shadow of the settings, taken at the write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wa_q  <= 8'h00;
      wd_q  <= 32'h0000_0000;
      ctl_q <= 8'h00;
      div_q <= 7'h00;
      pol_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) wa_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata;
      if (s_axi_bvalid && s_axi_bready) begin
        if (wa_q == spm_pkg::OFS_CONTROL) ctl_q <= wd_q[7:0];
        if (wa_q == spm_pkg::OFS_CONFIG) pol_q <= wd_q[spm_pkg::CFG_POL_BIT];
        if (wa_q == spm_pkg::OFS_DIVISOR) div_q <= wd_q[6:0];
      end
    end
  end

  assign n_w   = (div_q < spm_pkg::DIV_MIN_RAW) ? spm_pkg::RATIO_MIN : {1'b0, div_q} + 8'h01;
  assign s_w   = n_w >> 1;
  assign l_w   = n_w - s_w;
  assign ev_w  = (serial_bit_clock != sclk_q) || (slave_select_strobe_n != ssn_q);
  assign act_w = serial_bit_clock != pol_q;

  // ==========================================================
  // Length of each stable stretch of the bit clock and select pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_q <= 1'b0;
      ssn_q  <= 1'b1;
      hold_q <= 8'h00;
      nb_q   <= 4'h0;
    end else begin
      sclk_q <= serial_bit_clock;
      ssn_q  <= slave_select_strobe_n;
      hold_q <= ev_w ? 8'h01 : hold_q + 8'h01;
      if (ev_w && !slave_select_strobe_n && ssn_q) nb_q <= 4'h0;
      else if (ev_w && !slave_select_strobe_n && act_w) nb_q <= nb_q + 4'h1;
    end
  end

  // ==========================================================
  // Properties
  AST_MASTER_ONLY: assert property (ev_w && !slave_select_strobe_n && ssn_q |->
    ctl_q[spm_pkg::CTL_MASTER_BIT] && !ctl_q[spm_pkg::CTL_PHASE_BIT])
    else $error("word started outside master phase-cleared mode");
  AST_IDLE_LEVEL: assert property (slave_select_strobe_n && !s_axi_bvalid &&
    !$past(s_axi_bvalid) |-> serial_bit_clock == pol_q)
    else $error("idle bit clock differs from polarity");
  AST_LAUNCH_GAP: assert property (ev_w && !slave_select_strobe_n && act_w |->
    hold_q == l_w) else $error("launch edge not long half after previous event");
  AST_ACTIVE_PHASE: assert property (ev_w && !slave_select_strobe_n && !ssn_q &&
    !act_w |-> hold_q == s_w) else $error("active phase not the short half");
  AST_MOSI_STABLE: assert property (!slave_select_strobe_n && !ssn_q &&
    !(ev_w && act_w) |-> $stable(master_out_line)) else $error("data moved off launch edge");
  AST_IDLE_AT_SELECT: assert property (ev_w && !slave_select_strobe_n && ssn_q |->
    !act_w ##1 !act_w) else $error("bit clock not idle at select");
  AST_TRAIL: assert property (ev_w && slave_select_strobe_n && !ssn_q |->
    hold_q == l_w) else $error("select released at wrong time");
  AST_EIGHT_BITS: assert property (ev_w && slave_select_strobe_n && !ssn_q |->
    nb_q == 4'h8) else $error("word did not carry eight launches");

  cover property (ev_w && !slave_select_strobe_n && ssn_q && pol_q);
  cover property (ev_w && act_w && n_w[0]);
  cover property (ev_w && slave_select_strobe_n && !ssn_q);
endmodule : spm_properties

`default_nettype wire

// ===== spm_slave_model.sv
`default_nettype none

module spm_slave_model (
  input  wire logic       aclk,
  input  wire logic       pol,
  input  wire logic       sclk,
  input  wire logic       mosi,
  input  wire logic       ss_n,
  input  wire logic [7:0] reply,
  output var  logic       miso,
  output var  logic [7:0] got
);
  timeunit 1ns;
  timeprecision 1ps;
  int idx;

  initial begin
    miso = 1'b0;
    got  = 8'h00;
    idx  = 0;
  end

  // Released line toggles so a stale bit cannot pass as data
  always @(negedge aclk) begin
    if (ss_n === 1'b1) miso = ~miso;
  end

  always @(negedge ss_n) begin
    idx  = 7;
    miso = reply[7];
  end

  always @(sclk) begin
    if (ss_n === 1'b0 && sclk != pol && idx < 7) begin
      miso = reply[idx];
    end else if (ss_n === 1'b0 && sclk == pol) begin
      got = {got[6:0], mosi};
      idx = idx - 1;
    end
  end
endmodule : spm_slave_model

`default_nettype wire

// ===== spm_tb.sv
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, miso, pol;
  logic        awready, wready, bvalid, arready, rvalid, sclk, mosi, ss_n;
  logic [7:0]  awaddr, araddr, rpl, got;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rsp;
  int          miscompares, cmp_count, low_len, last_len;

  spm_top spm_top_i (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .serial_bit_clock(sclk), .master_out_line(mosi), .master_in_line(miso),
    .slave_select_strobe_n(ss_n));
  spm_slave_model spm_slave_model_i (.aclk, .pol, .sclk, .mosi, .ss_n, .reply(rpl), .miso,
    .got);

  initial aclk = 1'b0;
  always #2 aclk = ~aclk;

  always @(posedge aclk) begin
    if (ss_n === 1'b0) begin
      low_len <= low_len + 1;
    end else if (low_len != 0) begin
      last_len <= low_len;
      low_len  <= 0;
    end
  end

  // ==========================================================
  // Bus master and checks
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    while (!bvalid) @(posedge aclk);
    rsp = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    rd  = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  // ==========================================================
  // Scenarios
  task automatic t_regs();
    for (int i = 0; i < 6; i++) begin
      axi_rd(8'(i * 4));
      chk(rd, 32'h0000_0000, "reset value");
    end
    axi_rd(8'h18);
    chk({rd[29:0], rsp}, {30'h0, spm_pkg::RESP_SLVERR}, "unmapped read");
    axi_wr(8'h18, 32'h0000_0001);
    chk({30'h0, rsp}, {30'h0, spm_pkg::RESP_SLVERR}, "unmapped write");
  endtask : t_regs

  task automatic t_refused();
    for (int i = 0; i < 2; i++) begin
      axi_wr(spm_pkg::OFS_CONTROL, i ? 32'h0000_000c : 32'h0000_0000);
      axi_wr(spm_pkg::OFS_TXDATA, 32'h0000_00a5);
      axi_rd(spm_pkg::OFS_STATUS);
      chk({rd[30:0], ss_n}, 32'h0000_0001, "tx write refused");
    end
    axi_wr(spm_pkg::OFS_CONTROL, 32'h0000_0004);
  endtask : t_refused

  task automatic t_word(input logic [6:0] div, input logic p, input logic [7:0] tx,
                        input logic [7:0] rx);
    int n, s, l;
    n = (div < 3) ? 4 : div + 1;
    s = n / 2;
    l = n - s;
    pol <= p;
    rpl <= rx;
    axi_wr(spm_pkg::OFS_CONFIG, {25'h0, p, 6'h00});
    axi_wr(spm_pkg::OFS_DIVISOR, {25'h0, div});
    axi_wr(spm_pkg::OFS_TXDATA, {24'h0, tx});
    axi_rd(spm_pkg::OFS_STATUS);
    chk(rd, 32'h0000_0001, "busy in word");
    axi_wr(spm_pkg::OFS_TXDATA, {24'h0, ~tx});
    for (int i = 0; i < 2000 && ss_n !== 1'b1; i++) @(posedge aclk);
    chk({31'h0, ss_n}, 32'h0000_0001, "select released in time");
    repeat (2) @(posedge aclk);
    chk(last_len, l + 8 * n, "select low span");
    chk({24'h0, got}, {24'h0, tx}, "slave got");
    axi_rd(spm_pkg::OFS_RXDATA);
    // Two-flop input needs a short phase of three clocks
    if (s > 2) chk(rd, {24'h0, rx}, "rx word");
    axi_rd(spm_pkg::OFS_STATUS);
    chk(rd, 32'h0000_0002, "done set");
    axi_wr(spm_pkg::OFS_STATUS, 32'h0000_0002);
    axi_rd(spm_pkg::OFS_STATUS);
    chk({rd[30:0], sclk}, {31'h0, p}, "done cleared, idle level");
  endtask : t_word

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (10000) @(posedge aclk);
    miscompares++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    end_of_test();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, pol} <= 7'h00;
    {awaddr, araddr, rpl, wdata} <= 56'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_refused();
    t_word(7'h02, 1'h0, 8'ha5, 8'h3c);
    t_word(7'h00, 1'h1, 8'h5a, 8'hc3);
    t_word(7'h0c, 1'h0, 8'h96, 8'h81); // Bit clock under pin limit
    t_word(7'h0d, 1'h1, 8'h1e, 8'h7e); // Bit clock under pin limit
    t_word(7'h7f, 1'h0, 8'hc4, 8'h2b);
    end_of_test();
  end
endmodule : testbench

bind spm_top spm_properties spm_properties_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .serial_bit_clock, .master_out_line, .slave_select_strobe_n);

`default_nettype wire

// ===== spm_top.sv
// Our own choices: the register addresses and the AXI4-Lite slave port.
`default_nettype none

module spm_top (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [spm_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic [2:0]                  s_axi_awprot,
  input  wire logic                        s_axi_awvalid,
  output var  logic                        s_axi_awready,
  input  wire logic [spm_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output var  logic                        s_axi_wready,
  output var  logic [1:0]                  s_axi_bresp,
  output var  logic                        s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [spm_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic [2:0]                  s_axi_arprot,
  input  wire logic                        s_axi_arvalid,
  output var  logic                        s_axi_arready,
  output var  logic [spm_pkg::DATA_W-1:0]  s_axi_rdata,
  output var  logic [1:0]                  s_axi_rresp,
  output var  logic                        s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  output var  logic                        serial_bit_clock,
  output var  logic                        master_out_line,
  input  wire logic                        master_in_line,
  output var  logic                        slave_select_strobe_n
);

  // ==========================================================
  // Registers and state
  logic [spm_pkg::DATA_W-1:0] control_q;
  logic [spm_pkg::DATA_W-1:0] config_q;
  logic [spm_pkg::DIV_W-1:0]  divisor_q;
  logic [spm_pkg::WORD_W-1:0] tx_shift_q;
  logic [spm_pkg::WORD_W-1:0] rx_shift_q;
  logic [spm_pkg::WORD_W-1:0] rx_data_q;
  logic                       done_q;
  logic                       run_q;
  logic [spm_pkg::EDGE_W-1:0] edge_q;
  spm_pkg::spm_state_t        state_q;
  logic                       tick;
  logic                       miso_meta_q;
  logic                       miso_sync_q;

  logic                       aw_got_q;
  logic                       w_got_q;
  logic [spm_pkg::ADDR_W-1:0] awaddr_q;
  logic [spm_pkg::DATA_W-1:0] wdata_q;
  logic                       wstrb0_q;
  logic                       wr_fire;
  logic                       wr_ok;
  logic                       start;
  logic                       clear_done;
  logic                       word_end;
  logic                       polarity;
  logic [spm_pkg::DATA_W-1:0] rd_val;
  logic                       rd_ok;

  assign polarity = config_q[spm_pkg::CFG_POL_BIT];
  assign wr_fire  = aw_got_q && w_got_q && !s_axi_bvalid;

  always_comb begin
    wr_ok = (awaddr_q == spm_pkg::OFS_CONTROL) || (awaddr_q == spm_pkg::OFS_CONFIG)
         || (awaddr_q == spm_pkg::OFS_DIVISOR) || (awaddr_q == spm_pkg::OFS_TXDATA)
         || (awaddr_q == spm_pkg::OFS_STATUS);
  end

  assign start = wr_fire && wstrb0_q && (awaddr_q == spm_pkg::OFS_TXDATA)
              && (state_q == spm_pkg::SPM_IDLE)
              && control_q[spm_pkg::CTL_MASTER_BIT]
              && !control_q[spm_pkg::CTL_PHASE_BIT];
  assign clear_done = wr_fire && wstrb0_q && (awaddr_q == spm_pkg::OFS_STATUS)
                   && wdata_q[spm_pkg::STS_DONE_BIT];
  assign word_end = (state_q == spm_pkg::SPM_XFER) && tick
                 && (edge_q == spm_pkg::EDGE_LAST);

  // ==========================================================
  // Write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q      <= 1'b0;
      s_axi_awready <= 1'b1;
      awaddr_q      <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_q      <= 1'b1;
      s_axi_awready <= 1'b0;
      awaddr_q      <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_got_q      <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_q      <= 1'b0;
      s_axi_wready <= 1'b1;
      wdata_q      <= '0;
      wstrb0_q     <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_q      <= 1'b1;
      s_axi_wready <= 1'b0;
      wdata_q      <= s_axi_wdata;
      wstrb0_q     <= s_axi_wstrb[0];
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_got_q      <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= spm_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? spm_pkg::RESP_OKAY : spm_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Only byte lane 0 carries live fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_q <= spm_pkg::CONTROL_RST;
      config_q  <= spm_pkg::CONFIG_RST;
      divisor_q <= spm_pkg::DIVISOR_RST;
    end else if (wr_fire && wstrb0_q) begin
      if (awaddr_q == spm_pkg::OFS_CONTROL) begin
        control_q <= {24'h00_0000, wdata_q[7:0]};
      end else if (awaddr_q == spm_pkg::OFS_CONFIG) begin
        config_q <= {24'h00_0000, wdata_q[7:0]};
      end else if (awaddr_q == spm_pkg::OFS_DIVISOR) begin
        divisor_q <= wdata_q[spm_pkg::DIV_W-1:0];
      end
    end
  end

  // ==========================================================
  // Read channel
  always_comb begin
    rd_val = '0;
    rd_ok  = 1'b1;
    if (s_axi_araddr == spm_pkg::OFS_CONTROL) begin
      rd_val = control_q;
    end else if (s_axi_araddr == spm_pkg::OFS_CONFIG) begin
      rd_val = config_q;
    end else if (s_axi_araddr == spm_pkg::OFS_DIVISOR) begin
      rd_val[spm_pkg::DIV_W-1:0] = divisor_q;
    end else if (s_axi_araddr == spm_pkg::OFS_TXDATA) begin
      rd_val[spm_pkg::WORD_W-1:0] = tx_shift_q;
    end else if (s_axi_araddr == spm_pkg::OFS_RXDATA) begin
      rd_val[spm_pkg::WORD_W-1:0] = rx_data_q;
    end else if (s_axi_araddr == spm_pkg::OFS_STATUS) begin
      rd_val[spm_pkg::STS_BUSY_BIT] = (state_q == spm_pkg::SPM_XFER);
      rd_val[spm_pkg::STS_DONE_BIT] = done_q;
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= spm_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= rd_ok ? spm_pkg::RESP_OKAY : spm_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================
  // Input synchroniser; adds two clocks of latency to the sample
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      miso_meta_q <= 1'b0;
      miso_sync_q <= 1'b0;
    end else begin
      miso_meta_q <= master_in_line;
      miso_sync_q <= miso_meta_q;
    end
  end

  // ==========================================================
  // Bit rate divider
  spm_bitrate u_bitrate (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (run_q),
    .divisor (divisor_q),
    .tick    (tick)
  );

  // ==========================================================
  // Word engine: ticks at even edge_q launch, at odd edge_q sample, edge_q 16 ends the word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q               <= spm_pkg::SPM_IDLE;
      run_q                 <= 1'b0;
      edge_q                <= '0;
      tx_shift_q            <= spm_pkg::WORD_RST;
      rx_shift_q            <= spm_pkg::WORD_RST;
      serial_bit_clock      <= 1'b0;
      master_out_line       <= 1'b0;
      slave_select_strobe_n <= 1'b1;
    end else begin
      case (state_q)
        spm_pkg::SPM_IDLE: begin
          serial_bit_clock <= polarity;
          if (start) begin
            state_q               <= spm_pkg::SPM_XFER;
            run_q                 <= 1'b1;
            edge_q                <= '0;
            tx_shift_q            <= wdata_q[spm_pkg::WORD_W-1:0];
            master_out_line       <= wdata_q[spm_pkg::WORD_W-1];
            slave_select_strobe_n <= 1'b0;
          end
        end
        spm_pkg::SPM_XFER: begin
          if (tick) begin
            edge_q <= edge_q + spm_pkg::EDGE_ONE;
            if (word_end) begin
              state_q               <= spm_pkg::SPM_IDLE;
              run_q                 <= 1'b0;
              slave_select_strobe_n <= 1'b1;
            end else if (!edge_q[0]) begin
              // Leaves idle level: rising at polarity 0
              serial_bit_clock <= ~polarity;
              master_out_line  <= tx_shift_q[spm_pkg::WORD_W-1];
            end else begin
              serial_bit_clock <= polarity;
              rx_shift_q <= {rx_shift_q[spm_pkg::WORD_W-2:0], miso_sync_q};
              tx_shift_q <= {tx_shift_q[spm_pkg::WORD_W-2:0], 1'b0};
            end
          end
        end
        default: begin
          state_q <= spm_pkg::SPM_IDLE;
        end
      endcase
    end
  end

  // Completion flag: a new word beats a same-cycle clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_q    <= 1'b0;
      rx_data_q <= spm_pkg::WORD_RST;
    end else if (word_end) begin
      done_q    <= 1'b1;
      rx_data_q <= rx_shift_q;
    end else if (clear_done) begin
      done_q <= 1'b0;
    end
  end

endmodule : spm_top

`default_nettype wire
